// file: upc_defines.svh
// Function
// - Port enable bit, resets to one
// - Base address from upper and lower bytes
// - Four-bit interrupt channel, resets to four
// - Bit seven selects multidrop mode
// - Parity position becomes address flag
// - Auto bit clear: software clears gate
// - Auto bit set: hardware clears on match
// - Direction pin high while transmitting
// - Polarity bit inverts direction pin
// - Sharing style bit, only when sharing
// - Sharing enable bit, resets to zero
// - Two-bit baud clock source select
// - Slave address pattern, resets to zero
// - Mask zero bits are given don't-care
// - Broadcast compares ORed pattern ones
// - Eight-bit slave address mask register
`ifndef UPC_DEFINES_SVH
`define UPC_DEFINES_SVH
`define UPC_OFS_ENABLE 8'h30
`define UPC_OFS_BASE_HI 8'h60
`define UPC_OFS_BASE_LO 8'h61
`define UPC_OFS_IRQ_SEL 8'h70
`define UPC_OFS_SHARE 8'hf0
`define UPC_OFS_CLK 8'hf2
`define UPC_OFS_SADDR 8'hf4
`define UPC_OFS_SADEN 8'hf5
`define UPC_OFS_GATE 8'hf8
`define UPC_RST_ENABLE 1'h1
`define UPC_RST_BASE_HI 8'h00
`define UPC_RST_BASE_LO 8'hf8
`define UPC_RST_IRQ 4'h4
`define UPC_RST_SADDR 8'h00
`define UPC_RST_SADEN 8'h00
`define UPC_BIT_MULTIDROP 7
`define UPC_BIT_AUTO 6
`define UPC_BIT_INV 5
`define UPC_BIT_RS485 4
`define UPC_BIT_STYLE 1
`define UPC_BIT_SHARE 0
`endif

// file: upc_pkg.sv
package upc_pkg;
    typedef logic [7:0] upc_byte_t;
    typedef enum logic [1:0] {
        UPC_CLK_1M8432,
        UPC_CLK_18M432,
        UPC_CLK_24M,
        UPC_CLK_14M769
    } upc_clk_e;
endpackage : upc_pkg

// file: upc_config.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "upc_defines.svh"
module upc_config (
    input wire logic mclk,
    input wire logic arst_n,
    input wire upc_pkg::upc_byte_t reg_addr,
    input wire upc_pkg::upc_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output upc_pkg::upc_byte_t reg_rdata,
    input wire logic rx_char_valid,
    input wire upc_pkg::upc_byte_t rx_char_data,
    input wire logic rx_char_flag,
    input wire logic tx_busy,
    input wire logic rts_n_uart,
    output logic rx_accept,
    output logic rx_is_address,
    output logic rts_n_pin,
    output logic port_enable_bit,
    output logic [15:0] io_base_address,
    output logic [3:0] interrupt_channel_field,
    output logic interrupt_sharing_enable,
    output logic interrupt_sharing_style,
    output upc_pkg::upc_clk_e baud_clock_source,
    output logic multidrop_enable,
    output logic parity_as_address,
    output logic receive_gate_flag
);
    import upc_pkg::*;

    logic en_r;
    upc_byte_t base_hi_r;
    upc_byte_t base_lo_r;
    logic [3:0] irq_r;
    logic md_r;
    logic auto_r;
    logic inv_r;
    logic rs485_r;
    logic style_r;
    logic share_r;
    upc_clk_e clk_r;
    upc_byte_t saddr_r;
    upc_byte_t saden_r;
    logic gate_r;
    upc_byte_t rdata_r;
    logic match;
    logic rts_n_a_r;
    logic rts_n_b_r;

    function automatic logic wr_hit(input upc_byte_t a, input upc_byte_t ofs);
        wr_hit = (a == ofs);
    endfunction : wr_hit

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            en_r <= `UPC_RST_ENABLE;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_ENABLE)) begin
            en_r <= reg_wdata[0];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            base_hi_r <= `UPC_RST_BASE_HI;
            base_lo_r <= `UPC_RST_BASE_LO;
        end else if (reg_wr) begin
            if (wr_hit(reg_addr, `UPC_OFS_BASE_HI)) begin
                base_hi_r <= reg_wdata;
            end else if (wr_hit(reg_addr, `UPC_OFS_BASE_LO)) begin
                base_lo_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= `UPC_RST_IRQ;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_IRQ_SEL)) begin
            irq_r <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            md_r <= 1'b0;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_SHARE)) begin
            md_r <= reg_wdata[`UPC_BIT_MULTIDROP];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            auto_r <= 1'b0;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_SHARE)) begin
            auto_r <= reg_wdata[`UPC_BIT_AUTO];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            inv_r <= 1'b0;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_SHARE)) begin
            inv_r <= reg_wdata[`UPC_BIT_INV];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rs485_r <= 1'b0;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_SHARE)) begin
            rs485_r <= reg_wdata[`UPC_BIT_RS485];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            style_r <= 1'b0;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_SHARE)) begin
            style_r <= reg_wdata[`UPC_BIT_STYLE];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            share_r <= 1'b0;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_SHARE)) begin
            share_r <= reg_wdata[`UPC_BIT_SHARE];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            clk_r <= UPC_CLK_1M8432;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_CLK)) begin
            clk_r <= upc_clk_e'(reg_wdata[1:0]);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            saddr_r <= `UPC_RST_SADDR;
            saden_r <= `UPC_RST_SADEN;
        end else if (reg_wr) begin
            if (wr_hit(reg_addr, `UPC_OFS_SADDR)) begin
                saddr_r <= reg_wdata;
            end else if (wr_hit(reg_addr, `UPC_OFS_SADEN)) begin
                saden_r <= reg_wdata;
            end
        end
    end

    // Given: compare where mask is one; broadcast: compare where pattern|mask is one
    logic [7:0] given_hit;
    logic [7:0] bcast_hit;
    logic [7:0] bcast_ref;

    assign bcast_ref = saddr_r | saden_r;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_match_bit
            assign given_hit[gi] = !saden_r[gi] || (rx_char_data[gi] == saddr_r[gi]);
            assign bcast_hit[gi] = !bcast_ref[gi] || rx_char_data[gi];
        end
    endgenerate

    always_comb begin
        match = (&given_hit) || (&bcast_hit);
    end

    // Gate flag: set by software write of one, cleared by software or by a hardware match
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gate_r <= 1'b0;
        end else if (md_r && auto_r && rx_char_valid && rx_char_flag && match) begin
            gate_r <= 1'b0;
        end else if (reg_wr && wr_hit(reg_addr, `UPC_OFS_GATE)) begin
            gate_r <= reg_wdata[0];
        end
    end

    always_comb begin
        rx_is_address = md_r && rx_char_flag;
        rx_accept = rx_char_valid && en_r && !(md_r && gate_r && !rx_char_flag);
    end

    // RTS from the UART core is same clock; only registered here
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rts_n_a_r <= 1'b1;
        end else begin
            rts_n_a_r <= rts_n_uart;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rts_n_b_r <= 1'b1;
        end else if (rs485_r) begin
            rts_n_b_r <= tx_busy ^ inv_r;
        end else begin
            rts_n_b_r <= rts_n_a_r;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `UPC_OFS_ENABLE) begin
                rdata_r <= {7'h00, en_r};
            end else if (reg_addr == `UPC_OFS_BASE_HI) begin
                rdata_r <= base_hi_r;
            end else if (reg_addr == `UPC_OFS_BASE_LO) begin
                rdata_r <= base_lo_r;
            end else if (reg_addr == `UPC_OFS_IRQ_SEL) begin
                rdata_r <= {4'h0, irq_r};
            end else if (reg_addr == `UPC_OFS_SHARE) begin
                rdata_r <= {md_r, auto_r, inv_r, rs485_r, 2'h0, style_r, share_r};
            end else if (reg_addr == `UPC_OFS_CLK) begin
                rdata_r <= {6'h00, clk_r};
            end else if (reg_addr == `UPC_OFS_SADDR) begin
                rdata_r <= saddr_r;
            end else if (reg_addr == `UPC_OFS_SADEN) begin
                rdata_r <= saden_r;
            end else if (reg_addr == `UPC_OFS_GATE) begin
                rdata_r <= {7'h00, gate_r};
            end else begin
                rdata_r <= 8'h00;
            end
        end else begin
            rdata_r <= 8'h00;
        end
    end

    always_comb begin
        reg_rdata = rdata_r;
        rts_n_pin = rts_n_b_r;
        port_enable_bit = en_r;
        io_base_address = {base_hi_r, base_lo_r};
        interrupt_channel_field = irq_r;
        interrupt_sharing_enable = share_r;
        interrupt_sharing_style = style_r && share_r;
        baud_clock_source = clk_r;
        multidrop_enable = md_r;
        parity_as_address = md_r;
        receive_gate_flag = gate_r;
    end
endmodule : upc_config

// file: upc_config_properties.sv
`timescale 1ns/1ps
module upc_config_checker (
    input wire logic mclk,
    input wire logic arst_n,
    input wire upc_pkg::upc_byte_t reg_addr,
    input wire upc_pkg::upc_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire upc_pkg::upc_byte_t reg_rdata,
    input wire logic rx_char_valid,
    input wire logic rx_char_flag,
    input wire logic rx_accept,
    input wire logic rx_is_address,
    input wire logic port_enable_bit,
    input wire logic interrupt_sharing_enable,
    input wire logic interrupt_sharing_style,
    input wire upc_pkg::upc_clk_e baud_clock_source,
    input wire logic multidrop_enable,
    input wire logic receive_gate_flag
);
    import upc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence wr_at(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    en_write_a: assert property (wr_at(8'h30) |=> port_enable_bit == $past(reg_wdata[0]))
        else $error("enable bit not written");
    md_write_a: assert property (wr_at(8'hf0) |=> multidrop_enable == $past(reg_wdata[7]))
        else $error("multidrop bit not written");
    clk_write_a: assert property (wr_at(8'hf2) |=> baud_clock_source == $past(reg_wdata[1:0]))
        else $error("clock source not written");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    addr_flag_a: assert property (rx_is_address == (multidrop_enable && rx_char_flag))
        else $error("address flag wrong");
    style_gate_a: assert property (interrupt_sharing_style |-> interrupt_sharing_enable)
        else $error("style active without sharing");
    drop_data_a: assert property (multidrop_enable && receive_gate_flag && !rx_char_flag |-> !rx_accept)
        else $error("data accepted while gated");
    plain_accept_a: assert property (rx_char_valid && port_enable_bit && !multidrop_enable |-> rx_accept)
        else $error("character refused");
    gate_keep_a: assert property (receive_gate_flag && !rx_char_valid && !(reg_wr && reg_addr == 8'hf8)
        |=> receive_gate_flag)
        else $error("gate cleared without cause");
endmodule : upc_config_checker

// file: tb_upc_config.sv
`timescale 1ns/1ps
module tb_upc_config;
    import upc_pkg::*;
    logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, valid = 0, flag = 0, tx_busy = 0, rts_u = 1;
    upc_byte_t addr = 0, wdata = 0, rdata, cdata = 0;
    logic acc, is_addr, rts_pin, en, sh, sty, md, par, gate;
    logic [15:0] base;
    logic [3:0] irq;
    upc_clk_e clk_src;
    int err_total = 0, n_compared = 0;
    always #10 mclk = ~mclk;
    upc_config i_dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .rx_char_valid(valid), .rx_char_data(cdata), .rx_char_flag(flag),
        .tx_busy(tx_busy), .rts_n_uart(rts_u), .rx_accept(acc), .rx_is_address(is_addr), .rts_n_pin(rts_pin),
        .port_enable_bit(en), .io_base_address(base), .interrupt_channel_field(irq),
        .interrupt_sharing_enable(sh), .interrupt_sharing_style(sty), .baud_clock_source(clk_src),
        .multidrop_enable(md), .parity_as_address(par), .receive_gate_flag(gate));
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task wr(input upc_byte_t a, input upc_byte_t d);
        @(posedge mclk);
        addr <= a; wdata <= d; reg_wr <= 1;
        @(posedge mclk);
        reg_wr <= 0;
        #1;
    endtask : wr
    task rd(input upc_byte_t a, input upc_byte_t e);
        @(posedge mclk);
        addr <= a; reg_rd <= 1;
        @(posedge mclk);
        reg_rd <= 0;
        #1 chk("rdata", rdata, e);
    endtask : rd
    task ch(input upc_byte_t d, input logic f, input logic e_acc);
        @(posedge mclk);
        valid <= 1; cdata <= d; flag <= f;
        #1 chk("accept", acc, e_acc);
        chk("is_addr", is_addr, md & f);
        @(posedge mclk);
        valid <= 0;
        #1;
    endtask : ch
    task t_reset;
        upc_byte_t a[8] = '{8'h30, 8'h61, 8'h70, 8'hf0, 8'hf2, 8'hf4, 8'hf5, 8'h31};
        upc_byte_t e[8] = '{8'h01, 8'hf8, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) rd(a[i], e[i]);
        chk("base", base, 16'h00f8);
    endtask : t_reset
    task t_regs;
        upc_byte_t a[8] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hf0, 8'hf2, 8'hf4, 8'h10};
        upc_byte_t e[8] = '{8'h01, 8'hff, 8'hff, 8'h0f, 8'hf3, 8'h03, 8'hff, 8'h00};
        for (int i = 0; i < 8; i++) begin
            wr(a[i], 8'hff);
            rd(a[i], e[i]);
        end
        chk("base", base, 16'hffff);
        chk("irq", irq, 4'hf);
        wr(8'h30, 8'h00);
        chk("en", en, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(8'hf2, i[7:0]);
            chk("clk", clk_src, i[1:0]);
            wr(8'hf0, i[7:0] | 8'h02);
            chk("share", {sh, sty}, {i[0], i[0]});
        end
    endtask : t_regs
    task t_rts;
        logic [7:0] m[4] = '{8'h10, 8'h10, 8'h30, 8'h30};
        for (int i = 0; i < 4; i++) begin
            wr(8'hf0, m[i]);
            @(posedge mclk);
            tx_busy <= i[0];
            repeat (2) @(posedge mclk);
            #1 chk("rts", rts_pin, i[0] ^ m[i][5]);
        end
        wr(8'hf0, 8'h20);
        @(posedge mclk);
        rts_u <= 0;
        repeat (3) @(posedge mclk);
        #1 chk("rts", rts_pin, 1'b0);
    endtask : t_rts
    task t_multidrop;
        upc_byte_t c[3] = '{8'h58, 8'hfd, 8'h00};
        wr(8'h30, 8'h01);
        wr(8'hf4, 8'h5c);
        wr(8'hf5, 8'hf9);
        wr(8'hf0, 8'hc0);
        for (int i = 0; i < 3; i++) begin
            wr(8'hf8, 8'h01);
            ch(8'h58, 0, 0);
            ch(c[i], 1, 1);
            chk("gate", gate, i == 2);
        end
        wr(8'hf0, 8'h80);
        wr(8'hf8, 8'h01);
        ch(8'h58, 1, 1);
        chk("gate", gate, 1'b1);
        wr(8'hf8, 8'h00);
        ch(8'h33, 0, 1);
        chk("gate", gate, 1'b0);
        chk("parity", par, 1'b1);
    endtask : t_multidrop
    task stop_test;
        if (err_total == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1;
        t_reset();
        t_regs();
        t_rts();
        t_multidrop();
        stop_test();
    end
endmodule : tb_upc_config
bind upc_config upc_config_checker i_chk (.*);
